// *** bench/ldis_i2c_slave_props.sv ***
// checker for the led driver serial slave interface
`timescale 1ns/100ps
`default_nettype none
module ldis_i2c_slave_props (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] addr_strap_in,
  input wire logic sda_drv_out,
  input wire logic sda_oe_out,
  input wire logic reg_wr_strobe_out,
  input wire logic [7:0] reg_wr_addr_out,
  input wire logic [7:0] reg_wr_data_out,
  input wire logic bus_reset_call_out,
  input wire logic link_busy_out
);
  property p_oe_scl_low;
    @(posedge link_clk_in) disable iff (rst_in)
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed with clock high");
  property p_oe_hold;
    @(posedge link_clk_in) disable iff (rst_in)
    $rose(sda_oe_out) |-> sda_oe_out [*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data pull dropped too soon");
  property p_stop_release;
    @(posedge link_clk_in) disable iff (rst_in)
    scl_in && $rose(sda_in) |=> !sda_oe_out [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("data driven after stop");
  property p_start_busy;
    @(posedge ref_clk_in) disable iff (rst_in)
    scl_in && $fell(sda_in) |-> ##[1:24] link_busy_out;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start not seen");
  property p_stop_idle;
    @(posedge ref_clk_in) disable iff (rst_in)
    scl_in && $rose(sda_in) |-> ##[1:24] !link_busy_out;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("engine not idle after stop");
  property p_strobe_pulse;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(reg_wr_strobe_out) |=> !reg_wr_strobe_out;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("write strobe longer than one cycle");
  property p_wr_held;
    @(posedge ref_clk_in) disable iff (rst_in)
    $changed(reg_wr_addr_out) || $changed(reg_wr_data_out)
      |-> reg_wr_strobe_out;
  endproperty
  a_wr_held: assert property (p_wr_held)
    else $error("write fields moved without strobe");
  property p_rcall_pulse;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(bus_reset_call_out) |=> !bus_reset_call_out [*4];
  endproperty
  a_rcall_pulse: assert property (p_rcall_pulse)
    else $error("reset call pulse too long");
endmodule
bind ldis_i2c_slave ldis_i2c_slave_props u_props (.ref_clk_in, .rst_in,
  .link_clk_in, .scl_in, .sda_in, .addr_strap_in, .sda_drv_out, .sda_oe_out,
  .reg_wr_strobe_out, .reg_wr_addr_out, .reg_wr_data_out,
  .bus_reset_call_out, .link_busy_out);
`default_nettype wire

// *** bench/ldis_i2c_slave_tb_top.sv ***
// self-checking bench of the led driver serial slave interface
`timescale 1ns/100ps
`default_nettype none
module ldis_i2c_slave_tb_top;
  import ldis_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, oe, drv, stb, rcall, busy, a;
  logic [7:0] wa, wd, rx;
  // strap kept clear of the reserved call addresses
  logic [6:0] strap = 7'h2a;
  int failures = 0;
  int checks_done = 0;
  int stb_n = 0;
  int rcall_n = 0;
  initial forever #25 ref_clk = ~ref_clk;
  // link clock offset so it never lines up with the core clock
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  ldis_i2c_slave uut (.ref_clk_in(ref_clk), .rst_in(rst),
    .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .addr_strap_in(strap), .sda_drv_out(drv), .sda_oe_out(oe),
    .reg_wr_strobe_out(stb), .reg_wr_addr_out(wa), .reg_wr_data_out(wd),
    .bus_reset_call_out(rcall), .link_busy_out(busy));
  ldis_master_model mdl (.ref_clk_in(ref_clk), .sda_oe_in(oe),
    .scl_out(scl), .sda_out(sda));
  always @(posedge ref_clk) begin
    if (stb === 1'b1) stb_n++;
    if (rcall === 1'b1) rcall_n++;
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic snd(input logic [7:0] b, input logic ack);
    mdl.xfer_byte(b, 1'b1, rx, a);
    chk(a === ~ack, "ack level wrong");
  endtask
  task automatic rcv(input logic mack, input logic [7:0] exp);
    mdl.xfer_byte(8'hff, mack, rx, a);
    chk(rx === exp, "read data wrong");
    chk(a === mack, "read ack slot level wrong");
  endtask
  task automatic t_write_bcast();
    int n0;
    n0 = stb_n;
    mdl.start();
    snd({strap, 1'b0}, 1'b1);
    snd(LDIS_REG_BCAST, 1'b1);
    snd(8'h66, 1'b1);
    mdl.stop();
    chk(stb_n === n0 + 1 && wa === LDIS_REG_BCAST, "strobe wrong");
    chk(wd === 8'h66, "write data wrong");
    mdl.start();
    snd({7'h66, 1'b0}, 1'b1);
    mdl.stop();
    mdl.start();
    snd({LDIS_BCAST_RST, 1'b0}, 1'b0);
    mdl.stop();
  endtask
  task automatic t_nomatch();
    int n0;
    n0 = stb_n;
    mdl.start();
    snd({7'h7a, 1'b0}, 1'b0);
    snd(8'h00, 1'b0);
    snd(8'h11, 1'b0);
    mdl.stop();
    chk(stb_n === n0, "ignored transfer wrote");
  endtask
  task automatic t_sub();
    int n0;
    n0 = stb_n;
    mdl.start();
    snd({strap, 1'b0}, 1'b1);
    snd(LDIS_REG_MODE, 1'b1);
    snd(8'h0b, 1'b1);
    snd({1'b0, LDIS_SUB1_RST}, 1'b1);
    snd({1'b0, LDIS_SUB2_RST}, 1'b1);
    snd(8'h5e, 1'b1);
    mdl.stop();
    chk(stb_n === n0 + 4 && wa === LDIS_REG_SUB1 + 8'h02, "autoinc");
    chk(wd === 8'h5e, "subgroup write data wrong");
    mdl.start();
    snd({LDIS_SUB1_RST, 1'b0}, 1'b1);
    mdl.stop();
    mdl.start();
    snd({7'h5e, 1'b0}, 1'b1);
    mdl.stop();
    mdl.start();
    snd({LDIS_SUB2_RST, 1'b0}, 1'b0);
    mdl.stop();
  endtask
  task automatic t_read();
    mdl.start();
    snd({strap, 1'b0}, 1'b1);
    snd(LDIS_REG_SUB1, 1'b1);
    mdl.start();
    snd({strap, 1'b1}, 1'b1);
    rcv(1'b0, {1'b0, LDIS_SUB1_RST});
    rcv(1'b1, {1'b0, LDIS_SUB2_RST});
    mdl.stop();
  endtask
  task automatic t_reset_call();
    int r0;
    r0 = rcall_n;
    mdl.start();
    snd({LDIS_RESET_CALL_ADDR, 1'b0}, 1'b1);
    snd(LDIS_RESET_BYTE1, 1'b1);
    snd(8'h5c, 1'b0);
    mdl.stop();
    chk(rcall_n === r0, "bad call caused reset");
    mdl.start();
    snd({7'h66, 1'b0}, 1'b1);
    mdl.stop();
    mdl.start();
    snd({LDIS_RESET_CALL_ADDR, 1'b0}, 1'b1);
    snd(LDIS_RESET_BYTE1, 1'b1);
    snd(LDIS_RESET_BYTE2, 1'b1);
    mdl.stop();
    chk(rcall_n === r0 + 1, "no reset pulse");
    mdl.start();
    snd({7'h66, 1'b0}, 1'b0);
    mdl.start();
    snd({LDIS_SUB1_RST, 1'b0}, 1'b0);
    mdl.start();
    snd({LDIS_BCAST_RST, 1'b0}, 1'b1);
    mdl.stop();
  endtask
  task automatic tally_and_finish();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the scenarios need about 14000 core clocks; allow roughly twice that
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge link_clk);
    t_write_bcast();
    t_nomatch();
    t_sub();
    t_read();
    t_reset_call();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** bench/ldis_master_model.sv ***
// bus master model driving the serial clock and data lines
`timescale 1ns/100ps
`default_nettype none
module ldis_master_model (
  input wire logic ref_clk_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic pull_low = 1'b0;
  // pull-up: a released line reads high, never a stale value
  assign sda_out = ~(pull_low | sda_oe_in);
  initial scl_out = 1'b1;
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // data moves only with clock low
  task automatic bitx(input logic b, output logic r);
    wait_n(10);
    pull_low = ~b;
    wait_n(10);
    scl_out = 1'b1;
    wait_n(10);
    r = sda_out;
    wait_n(10);
    scl_out = 1'b0;
  endtask
  // start from idle or as repeated start
  task automatic start();
    wait_n(10);
    pull_low = 1'b0;
    wait_n(10);
    scl_out = 1'b1;
    wait_n(20);
    pull_low = 1'b1;
    wait_n(20);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    wait_n(10);
    pull_low = 1'b1;
    wait_n(10);
    scl_out = 1'b1;
    wait_n(20);
    pull_low = 1'b0;
    wait_n(40);
  endtask
  // eight bits then ack slot, master acks or withholds
  task automatic xfer_byte(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic r9);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], r);
      rx[i] = r;
    end
    bitx(mack, r9);
  endtask
endmodule
`default_nettype wire

// *** rtl/ldis_i2c_slave.sv ***
// serial slave interface with multi-address match and bus reset call
// Function
// - one bit per clock, data stable while high
// - data fall while clock high starts
// - data rise while clock high stops
// - eight data bits then one acknowledge slot
// - extra ack clock, transmitter releases data
// - receiver acks by holding data low
// - no master ack ends read, line released
// - individual address from seven strap pins
// - three programmable subgroup addresses
// - ack individual or assigned subgroup address
// - broadcast group address is writable register
// - correct reset call plus stop restores defaults
// - wrong reset call format gets no ack
`timescale 1ns/100ps
`default_nettype none

module ldis_i2c_slave (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] addr_strap_in,
  output logic sda_drv_out,
  output logic sda_oe_out,
  output logic reg_wr_strobe_out,
  output logic [7:0] reg_wr_addr_out,
  output logic [7:0] reg_wr_data_out,
  output logic bus_reset_call_out,
  output logic link_busy_out
);
  import ldis_pkg::*;

  // ---------------------------------------------------------------
  // link side: line synchronisers
  // ---------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [6:0] strap_s1_q, strap_s2_q;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {strap_s1_q, strap_s2_q} <= 14'h0000;
    end else begin
      {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_in};
      {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_in};
      {strap_s2_q, strap_s1_q} <= {strap_s1_q, addr_strap_in};
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;

  // sample on rise, change on fall
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_seen = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_seen = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

  // ---------------------------------------------------------------
  // link side: state
  // ---------------------------------------------------------------
  ldis_state_t state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic first_q, first_d;
  logic mack_q, mack_d;
  logic oe_q, oe_d;
  logic rc_mode_q, rc_mode_d;
  logic [1:0] rc_stage_q, rc_stage_d;
  logic [3:0] mode_q, mode_d;
  logic [6:0] sub_q [LDIS_NUM_SUB];
  logic [6:0] sub_d [LDIS_NUM_SUB];
  logic [6:0] bcast_q, bcast_d;
  logic wr_tgl_q, wr_tgl_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic rc_tgl_q, rc_tgl_d;
  logic busy_q, busy_d;

  // ---------------------------------------------------------------
  // address match
  // ---------------------------------------------------------------
  logic [LDIS_NUM_SUB-1:0] sub_hit;
  logic addr_hit, rc_hit;

  for (genvar i = 0; i < LDIS_NUM_SUB; i++) begin : g_sub
    assign sub_hit[i] = mode_q[LDIS_MODE_SUB_LSB + i] &&
                        (sub_q[i] == shift_q[7:1]);
  end

  // broadcast address taken from its register
  assign addr_hit = (shift_q[7:1] == strap_s2_q) ||
                    (mode_q[LDIS_MODE_BCAST_BIT] &&
                     (bcast_q == shift_q[7:1])) ||
                    (|sub_hit);
  assign rc_hit = (shift_q[7:1] == LDIS_RESET_CALL_ADDR);

  // ---------------------------------------------------------------
  // local register read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == LDIS_REG_MODE) begin
      rd_byte = {4'h0, mode_q};
    end else if (ptr_q == LDIS_REG_BCAST) begin
      rd_byte = {1'b0, bcast_q};
    end
    for (int i = 0; i < LDIS_NUM_SUB; i++) begin
      if (ptr_q == LDIS_REG_SUB1 + 8'(i)) begin
        rd_byte = {1'b0, sub_q[i]};
      end
    end
  end

  // ---------------------------------------------------------------
  // link side: next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sub_d = sub_q;
    {bit_cnt_d, shift_d, ptr_d, rw_d, first_d, mack_d, oe_d} =
      {bit_cnt_q, shift_q, ptr_q, rw_q, first_q, mack_q, oe_q};
    {rc_mode_d, rc_stage_d, wr_tgl_d, rc_tgl_d} =
      {rc_mode_q, rc_stage_q, wr_tgl_q, rc_tgl_q};
    {mode_d, bcast_d, wr_addr_d, wr_data_d} =
      {mode_q, bcast_q, wr_addr_q, wr_data_q};

    if (start_seen || stop_seen) begin
      state_d = start_seen ? LDIS_ADDR : LDIS_IDLE;
      bit_cnt_d = 4'h0;
      oe_d = 1'b0;
      rc_mode_d = 1'b0;
      rc_stage_d = 2'h0;
      // restore defaults after good reset call
      if (stop_seen && rc_mode_q && (rc_stage_q == LDIS_RESET_DONE)) begin
        mode_d = LDIS_MODE_RST;
        sub_d[0] = LDIS_SUB1_RST;
        sub_d[1] = LDIS_SUB2_RST;
        sub_d[2] = LDIS_SUB3_RST;
        bcast_d = LDIS_BCAST_RST;
        ptr_d = 8'h00;
        rc_tgl_d = !rc_tgl_q;
      end
    end else begin
      unique case (state_q)
        LDIS_IDLE, LDIS_IGNORE: begin
        end
        LDIS_ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && (bit_cnt_q == LDIS_BYTE_BITS)) begin
            rw_d = shift_q[0];
            first_d = 1'b1;
            bit_cnt_d = 4'h0;
            if (rc_hit && !shift_q[0]) begin
              rc_mode_d = 1'b1;
              oe_d = 1'b1;
              state_d = LDIS_WACK;
            end else if (!rc_hit && addr_hit) begin
              oe_d = 1'b1;
              state_d = LDIS_WACK;
            end else begin
              state_d = LDIS_IGNORE;
            end
          end
        end
        LDIS_WACK: begin
          // low held across the whole ack clock
          if (scl_fall) begin
            if (rw_q) begin
              oe_d = !rd_byte[7];
              shift_d = {rd_byte[6:0], 1'b0};
              bit_cnt_d = 4'h1;
              ptr_d = ptr_q + 8'h01;
              state_d = LDIS_READ;
            end else begin
              oe_d = 1'b0;
              bit_cnt_d = 4'h0;
              state_d = LDIS_WRITE;
            end
          end
        end
        LDIS_WRITE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && (bit_cnt_q == LDIS_BYTE_BITS)) begin
            // ack slot after every eighth bit
            bit_cnt_d = 4'h0;
            oe_d = 1'b1;
            state_d = LDIS_WACK;
            if (rc_mode_q) begin
              // wrong format: no ack, no reset
              if ((rc_stage_q == 2'h0) && (shift_q == LDIS_RESET_BYTE1)) begin
                rc_stage_d = 2'h1;
              end else if ((rc_stage_q == 2'h1) &&
                           (shift_q == LDIS_RESET_BYTE2)) begin
                rc_stage_d = LDIS_RESET_DONE;
              end else begin
                rc_stage_d = 2'h0;
                oe_d = 1'b0;
                state_d = LDIS_IGNORE;
              end
            end else if (first_q) begin
              ptr_d = shift_q;
              first_d = 1'b0;
            end else begin
              if (ptr_q == LDIS_REG_MODE) begin
                mode_d = shift_q[3:0];
              end else if (ptr_q == LDIS_REG_BCAST) begin
                bcast_d = shift_q[6:0];
              end
              for (int i = 0; i < LDIS_NUM_SUB; i++) begin
                if (ptr_q == LDIS_REG_SUB1 + 8'(i)) begin
                  sub_d[i] = shift_q[6:0];
                end
              end
              wr_addr_d = ptr_q;
              wr_data_d = shift_q;
              wr_tgl_d = !wr_tgl_q;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        LDIS_READ: begin
          if (scl_fall) begin
            if (bit_cnt_q == LDIS_BYTE_BITS) begin
              // transmitter releases in the ack slot
              oe_d = 1'b0;
              state_d = LDIS_RACK;
            end else begin
              oe_d = !shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        LDIS_RACK: begin
          if (scl_rise) begin
            mack_d = !sda_s2_q;
          end else if (scl_fall) begin
            if (mack_q) begin
              // master ack asks for the next byte
              oe_d = !rd_byte[7];
              shift_d = {rd_byte[6:0], 1'b0};
              bit_cnt_d = 4'h1;
              ptr_d = ptr_q + 8'h01;
              state_d = LDIS_READ;
            end else begin
              // no ack: stay released for the stop
              state_d = LDIS_IGNORE;
            end
          end
        end
        default: begin
          state_d = LDIS_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
    busy_d = (state_d != LDIS_IDLE);
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= LDIS_IDLE;
      {bit_cnt_q, shift_q, ptr_q, rw_q, first_q, mack_q, oe_q} <= 24'h000000;
      {rc_mode_q, rc_stage_q, wr_tgl_q, rc_tgl_q, busy_q} <= 6'h00;
      {wr_addr_q, wr_data_q} <= 16'h0000;
      mode_q <= LDIS_MODE_RST;
      sub_q[0] <= LDIS_SUB1_RST;
      sub_q[1] <= LDIS_SUB2_RST;
      sub_q[2] <= LDIS_SUB3_RST;
      bcast_q <= LDIS_BCAST_RST;
    end else begin
      state_q <= state_d;
      sub_q <= sub_d;
      {bit_cnt_q, shift_q, ptr_q, rw_q, first_q, mack_q, oe_q} <=
        {bit_cnt_d, shift_d, ptr_d, rw_d, first_d, mack_d, oe_d};
      {rc_mode_q, rc_stage_q, wr_tgl_q, rc_tgl_q, busy_q} <=
        {rc_mode_d, rc_stage_d, wr_tgl_d, rc_tgl_d, busy_d};
      {mode_q, bcast_q, wr_addr_q, wr_data_q} <=
        {mode_d, bcast_d, wr_addr_d, wr_data_d};
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_drv_out = 1'b0;
  assign sda_oe_out = oe_q;

  // ---------------------------------------------------------------
  // core side: event crossing
  // ---------------------------------------------------------------
  // write address and data stay frozen in the link domain for a
  // whole byte time, far longer than the toggle needs to cross
  logic [2:0] wr_sync_q, wr_sync_d;
  logic [2:0] rc_sync_q, rc_sync_d;
  logic [1:0] busy_sync_q, busy_sync_d;
  logic strobe_q, strobe_d;
  logic rc_pulse_q, rc_pulse_d;
  logic [7:0] out_addr_q, out_addr_d;
  logic [7:0] out_data_q, out_data_d;

  always_comb begin
    wr_sync_d = {wr_sync_q[1:0], wr_tgl_q};
    rc_sync_d = {rc_sync_q[1:0], rc_tgl_q};
    busy_sync_d = {busy_sync_q[0], busy_q};
    strobe_d = wr_sync_q[2] ^ wr_sync_q[1];
    rc_pulse_d = rc_sync_q[2] ^ rc_sync_q[1];
    {out_addr_d, out_data_d} = {out_addr_q, out_data_q};
    if (strobe_d) begin
      {out_addr_d, out_data_d} = {wr_addr_q, wr_data_q};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {wr_sync_q, rc_sync_q, busy_sync_q, strobe_q, rc_pulse_q} <= 10'h000;
      {out_addr_q, out_data_q} <= 16'h0000;
    end else begin
      {wr_sync_q, rc_sync_q, busy_sync_q, strobe_q, rc_pulse_q} <=
        {wr_sync_d, rc_sync_d, busy_sync_d, strobe_d, rc_pulse_d};
      {out_addr_q, out_data_q} <= {out_addr_d, out_data_d};
    end
  end

  assign reg_wr_strobe_out = strobe_q;
  assign reg_wr_addr_out = out_addr_q;
  assign reg_wr_data_out = out_data_q;
  // rest of the chip returns to power-up values
  assign bus_reset_call_out = rc_pulse_q;
  assign link_busy_out = busy_sync_q[1];

endmodule

`default_nettype wire

// *** rtl/ldis_pkg.sv ***
// shared constants and types of the led driver serial slave interface
package ldis_pkg;

  // ---------------------------------------------------------------
  // bus addresses and bus reset call format
  // ---------------------------------------------------------------
  localparam logic [6:0] LDIS_RESET_CALL_ADDR = 7'h03;
  localparam logic [7:0] LDIS_RESET_BYTE1 = 8'h3c;
  localparam logic [7:0] LDIS_RESET_BYTE2 = 8'hc3;
  localparam logic [1:0] LDIS_RESET_DONE = 2'h2;

  // ---------------------------------------------------------------
  // local register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] LDIS_REG_MODE = 8'h00;
  localparam logic [7:0] LDIS_REG_SUB1 = 8'h01;
  localparam logic [7:0] LDIS_REG_BCAST = 8'h04;
  localparam int LDIS_NUM_SUB = 3;

  // ---------------------------------------------------------------
  // mode register fields and reset values
  // ---------------------------------------------------------------
  localparam int LDIS_MODE_BCAST_BIT = 0;
  localparam int LDIS_MODE_SUB_LSB = 1;
  localparam logic [3:0] LDIS_MODE_RST = 4'h1;
  localparam logic [6:0] LDIS_SUB1_RST = 7'h51;
  localparam logic [6:0] LDIS_SUB2_RST = 7'h52;
  localparam logic [6:0] LDIS_SUB3_RST = 7'h54;
  localparam logic [6:0] LDIS_BCAST_RST = 7'h50;

  // ---------------------------------------------------------------
  // bit counting
  // ---------------------------------------------------------------
  localparam logic [3:0] LDIS_BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    LDIS_IDLE = 3'b000,
    LDIS_ADDR = 3'b001,
    LDIS_WACK = 3'b010,
    LDIS_WRITE = 3'b011,
    LDIS_READ = 3'b100,
    LDIS_RACK = 3'b101,
    LDIS_IGNORE = 3'b110
  } ldis_state_t;

endpackage
